//--- sie_pkg.sv
// package of register offsets, field positions and reset values for the interrupt block
package sie_pkg;

  localparam int          SIE_ADDR_W        = 9;
  localparam int          SIE_DATA_W        = 32;
  localparam int          SIE_PIN_COUNT     = 6;
  localparam int          SIE_TIMER_W       = 16;

  // register offsets on the management port
  localparam logic [8:0]  SIE_OFF_STATUS    = 9'h058;
  localparam logic [8:0]  SIE_OFF_ENABLE    = 9'h05c;
  localparam logic [8:0]  SIE_OFF_PINCFG    = 9'h1e0;

  // status and enable bit positions (same layout in both registers)
  localparam int          SIE_BIT_SOFTWARE  = 31;
  localparam int          SIE_BIT_READY     = 30;
  localparam int          SIE_BIT_FABRIC    = 28;
  localparam int          SIE_BIT_PORT2     = 27;
  localparam int          SIE_BIT_PORT1     = 26;
  localparam int          SIE_BIT_TIMER     = 19;
  localparam int          SIE_BIT_PINS      = 12;

  localparam logic [31:0] SIE_EVENT_MASK    = 32'hdc08_1000;
  localparam logic [31:0] SIE_W1C_MASK      = 32'hc008_0000;

  // pin configuration field positions
  localparam int          SIE_TRIG_LSB      = 16;
  localparam int          SIE_DRV_LSB       = 0;

  localparam logic [31:0] SIE_STATUS_RST    = 32'h0000_0000;
  localparam logic [31:0] SIE_ENABLE_RST    = 32'h0000_0000;
  localparam logic [5:0]  SIE_PINFLD_RST    = 6'h00;

  localparam logic [15:0] SIE_TIMER_TOP     = 16'hffff;
  localparam logic [15:0] SIE_TIMER_ZERO    = 16'h0000;

endpackage : sie_pkg

//--- sie_pin_if.sv
// interface carrying pin configuration, pin levels, pin status and pin drive
`timescale 1ns/10ps
interface sie_pin_if #(parameter int N = 6);
  logic [N-1:0] trig_level;
  logic [N-1:0] drv_type;
  logic [N-1:0] out_data;
  logic [N-1:0] dir_out;
  logic [N-1:0] raw;
  logic [N-1:0] sts_en;
  logic [N-1:0] sts_clr;
  logic [N-1:0] sts;
  logic         event_any;
  logic [N-1:0] pin_o;
  logic [N-1:0] pin_oe_n;

  modport ctl (output trig_level, drv_type, out_data, dir_out, raw, sts_en, sts_clr,
               input  sts, event_any, pin_o, pin_oe_n);
  modport pins (input  trig_level, drv_type, out_data, dir_out, raw, sts_en, sts_clr,
                output sts, event_any, pin_o, pin_oe_n);
endinterface : sie_pin_if

//--- sie_pin_unit.sv
// pin level trigger status and pin output buffer control
`timescale 1ns/10ps
module sie_pin_unit
  import sie_pkg::*;
#(
  parameter int N = SIE_PIN_COUNT
) (
  input  wire logic clk,
  input  wire logic arst_n,
  sie_pin_if.pins   p
);

  logic [N-1:0] sts_r;
  logic [N-1:0] sts_nxt;
  logic [N-1:0] hit;
  logic         evt_r;
  logic [N-1:0] o_r;
  logic [N-1:0] oe_n_r;

  // RQ11 level trigger select
  assign hit     = ~(p.raw ^ p.trig_level);
  // a trigger level present in the clear cycle keeps the bit set
  assign sts_nxt = (sts_r & ~p.sts_clr) | hit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_r <= SIE_PINFLD_RST;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  // RQ16 enabled pin bits ORed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_r <= 1'b0;
    end else begin
      evt_r <= |(sts_nxt & p.sts_en);
    end
  end

  // RQ12 driver type select
  // RQ13 open drain drives only low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      o_r    <= SIE_PINFLD_RST;
      oe_n_r <= {N{1'b1}};
    end else begin
      for (int i = 0; i < N; i++) begin
        if (p.drv_type[i]) begin
          o_r[i]    <= p.out_data[i];
          oe_n_r[i] <= ~p.dir_out[i];
        end else begin
          o_r[i]    <= 1'b0;
          oe_n_r[i] <= ~(p.dir_out[i] & ~p.out_data[i]);
        end
      end
    end
  end

  assign p.sts       = sts_r;
  assign p.event_any = evt_r;
  assign p.pin_o     = o_r;
  assign p.pin_oe_n  = oe_n_r;

  // RQ13
  a_open_drain_high: assert property (@(posedge clk) disable iff (!arst_n)
    (!p.drv_type[0] && p.out_data[0]) |=> oe_n_r[0])
    else $error("open drain pin driven while data is one");
  // RQ11
  a_trigger_sets_status: assert property (@(posedge clk) disable iff (!arst_n)
    (p.raw == p.trig_level) |=> (sts_r == {N{1'b1}}))
    else $error("matching pin level did not set status");

endmodule : sie_pin_unit

//--- sie_wrap_det.sv
// detects the general purpose timer count wrapping from zero to its top value
`timescale 1ns/10ps
module sie_wrap_det
  import sie_pkg::*;
#(
  parameter int W = SIE_TIMER_W
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] count,
  output logic              wrap
);

  logic [W-1:0] prev_r;
  logic         seen_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= count;
      seen_r <= 1'b1;
    end
  end

  // RQ7 wrap past zero
  // seen_r blocks a false wrap on the first sample after reset
  assign wrap = seen_r && (prev_r == W'(SIE_TIMER_ZERO)) && (count == W'(SIE_TIMER_TOP));

  // RQ7
  a_wrap_only_down: assert property (@(posedge clk) disable iff (!arst_n)
    wrap |-> ($past(count) == '0 && count == '1))
    else $error("wrap flagged without zero to top step");

endmodule : sie_wrap_det

//--- sie_top.sv
// system interrupt status, enable and pin configuration block
//
// Function
// RQ1: Status bits show their source condition regardless of enables, except software bit.
// RQ2: Writing one clears a clearable status bit; writing zero leaves it.
// RQ3: Bit 31 sets when software enable goes high; cleared by writing one.
// RQ4: Bit 30 sets when device is ready after reset; cleared by writing one.
// RQ5: Read-only bit 28 follows the fabric pending event.
// RQ6: Read-only bits 27 and 26 follow port 2 and port 1 transceiver events.
// RQ7: Bit 19 sets when timer count wraps zero to top; write one clears.
// RQ8: Read-only bit 12 follows the general purpose pin event.
// RQ9: An enable bit decides whether its status event reaches the interrupt output.
// RQ10: Enable bits share status positions; other positions are reserved read-only.
// RQ11: Trigger level field 21:16 picks low or high level per pin.
// RQ12: Driver type field 5:0 picks open drain or push pull per pin.
// RQ13: Open drain pins drive low for data zero, float for data one.
// RQ14: Master indication is set whenever any enabled status bit is active.
// RQ15: With output enable clear the interrupt pin stays de-asserted.
// RQ16: Enabled pin status bits are ORed into the pin event bit.
// RQ17: Summary read-only bits clear once their source flags are all clear.
// RQ18: Fields reset to zero; reserved positions read zero and ignore writes.
`timescale 1ns/10ps
module sie_top
  import sie_pkg::*;
#(
  parameter int N_PINS = SIE_PIN_COUNT
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // management port
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [SIE_ADDR_W-1:0] reg_addr,
  input  wire logic [SIE_DATA_W-1:0] reg_wdata,
  output logic      [SIE_DATA_W-1:0] reg_rdata,
  output logic                       reg_rvalid,
  // event sources
  input  wire logic                  device_ready,
  input  wire logic                  fabric_pending,
  input  wire logic                  port2_transceiver_event,
  input  wire logic                  port1_transceiver_event,
  input  wire logic [SIE_TIMER_W-1:0] timer_count,
  // pin side, data/direction and pin status enables live elsewhere
  input  wire logic [N_PINS-1:0]     pin_in,
  input  wire logic [N_PINS-1:0]     pin_out_data,
  input  wire logic [N_PINS-1:0]     pin_dir_out,
  input  wire logic [N_PINS-1:0]     pin_event_status_enable,
  input  wire logic [N_PINS-1:0]     pin_status_clear,
  output logic      [N_PINS-1:0]     pin_status,
  output logic      [N_PINS-1:0]     pin_o,
  output logic      [N_PINS-1:0]     pin_oe_n,
  // interrupt output
  input  wire logic                  irq_output_enable,
  output logic                       irq_master,
  output logic                       irq_pin
);

  function automatic logic hit(input logic [SIE_ADDR_W-1:0] a,
                               input logic [SIE_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic                  wr_status;
  logic                  wr_enable;
  logic                  wr_pincfg;
  logic [31:0]           status_r;
  logic [31:0]           status_nxt;
  logic [31:0]           enable_r;
  logic [N_PINS-1:0]     trig_level_r;
  logic [N_PINS-1:0]     drv_type_r;
  logic                  ready_done_r;
  logic                  timer_wrap;
  logic                  sw_en_rise;
  logic [31:0]           w1c;
  logic [31:0]           set_bits;
  logic [31:0]           live_bits;
  logic                  master_nxt;
  logic [SIE_DATA_W-1:0] rdata_nxt;

  sie_pin_if #(.N(N_PINS)) pif ();

  assign wr_status = reg_wr && hit(reg_addr, SIE_OFF_STATUS);
  assign wr_enable = reg_wr && hit(reg_addr, SIE_OFF_ENABLE);
  assign wr_pincfg = reg_wr && hit(reg_addr, SIE_OFF_PINCFG);

  sie_wrap_det #(
    .W (SIE_TIMER_W)
  ) u_wrap (
    .clk    (clk),
    .arst_n (arst_n),
    .count  (timer_count),
    .wrap   (timer_wrap)
  );

  assign pif.trig_level = trig_level_r;
  assign pif.drv_type   = drv_type_r;
  assign pif.out_data   = pin_out_data;
  assign pif.dir_out    = pin_dir_out;
  assign pif.raw        = pin_in;
  assign pif.sts_en     = pin_event_status_enable;
  assign pif.sts_clr    = pin_status_clear;

  sie_pin_unit #(
    .N (N_PINS)
  ) u_pins (
    .clk    (clk),
    .arst_n (arst_n),
    .p      (pif.pins)
  );

  // RQ3 software enable rising
  assign sw_en_rise = wr_enable && reg_wdata[SIE_BIT_SOFTWARE] && !enable_r[SIE_BIT_SOFTWARE];

  // RQ2 write one clears
  assign w1c = wr_status ? (reg_wdata & SIE_W1C_MASK) : 32'h0000_0000;

  always_comb begin
    set_bits                   = 32'h0000_0000;
    set_bits[SIE_BIT_SOFTWARE] = sw_en_rise;
    // RQ4 ready once after reset
    set_bits[SIE_BIT_READY]    = device_ready && !ready_done_r;
    set_bits[SIE_BIT_TIMER]    = timer_wrap;
  end

  // RQ5 RQ6 RQ8 live summary bits
  always_comb begin
    live_bits                 = 32'h0000_0000;
    live_bits[SIE_BIT_FABRIC] = fabric_pending;
    live_bits[SIE_BIT_PORT2]  = port2_transceiver_event;
    live_bits[SIE_BIT_PORT1]  = port1_transceiver_event;
    live_bits[SIE_BIT_PINS]   = pif.event_any;
  end

  // RQ1 status follows sources, set beats clear
  // RQ17 summary bits are not sticky here
  assign status_nxt = (((status_r & ~w1c) | set_bits) & SIE_W1C_MASK) |
                      (live_bits & ~SIE_W1C_MASK & SIE_EVENT_MASK);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= SIE_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ready is flagged once per reset, so a late clear is not undone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_done_r <= 1'b0;
    end else if (device_ready) begin
      ready_done_r <= 1'b1;
    end
  end

  // RQ10 enable shares status layout
  // RQ18 reserved bits dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_r <= SIE_ENABLE_RST;
    end else if (wr_enable) begin
      enable_r <= reg_wdata & SIE_EVENT_MASK;
    end
  end

  // RQ11 RQ12 pin configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_level_r <= SIE_PINFLD_RST;
      drv_type_r   <= SIE_PINFLD_RST;
    end else if (wr_pincfg) begin
      trig_level_r <= reg_wdata[SIE_TRIG_LSB +: N_PINS];
      drv_type_r   <= reg_wdata[SIE_DRV_LSB +: N_PINS];
    end
  end

  // RQ9 RQ14 enabled status gating
  assign master_nxt = |(status_nxt & enable_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_master <= 1'b0;
    end else begin
      irq_master <= master_nxt;
    end
  end

  // RQ15 output gate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pin <= 1'b0;
    end else begin
      irq_pin <= master_nxt && irq_output_enable;
    end
  end

  // RQ18 unmapped and reserved read zero
  always_comb begin
    case (reg_addr)
      SIE_OFF_STATUS: rdata_nxt = status_r;
      SIE_OFF_ENABLE: rdata_nxt = enable_r;
      SIE_OFF_PINCFG: begin
        rdata_nxt                             = 32'h0000_0000;
        rdata_nxt[SIE_TRIG_LSB +: N_PINS]     = trig_level_r;
        rdata_nxt[SIE_DRV_LSB +: N_PINS]      = drv_type_r;
      end
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_status <= SIE_PINFLD_RST;
      pin_o      <= SIE_PINFLD_RST;
      pin_oe_n   <= {N_PINS{1'b1}};
    end else begin
      pin_status <= pif.sts;
      pin_o      <= pif.pin_o;
      pin_oe_n   <= pif.pin_oe_n;
    end
  end

  a_sw_bit_sets: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
    (wr_enable && reg_wdata[SIE_BIT_SOFTWARE] && !enable_r[SIE_BIT_SOFTWARE])
      |=> status_r[SIE_BIT_SOFTWARE])
    else $error("software status bit not set on enable rise");

  a_w1c_clears: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
    (wr_status && reg_wdata[SIE_BIT_TIMER] && !timer_wrap)
      |=> !status_r[SIE_BIT_TIMER])
    else $error("timer status bit survived write one clear");

  a_w0_keeps: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
    (status_r[SIE_BIT_READY] && !(wr_status && reg_wdata[SIE_BIT_READY]))
      |=> status_r[SIE_BIT_READY])
    else $error("ready status bit lost without write one");

  a_ready_once: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
    $rose(ready_done_r) |-> status_r[SIE_BIT_READY])
    else $error("ready status bit not set when device became ready");

  a_fabric_follows: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
    ##1 (status_r[SIE_BIT_FABRIC] == $past(fabric_pending)))
    else $error("fabric bit does not follow its source");

  a_phy_follows: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
    ##1 (status_r[SIE_BIT_PORT2:SIE_BIT_PORT1] ==
         {$past(port2_transceiver_event), $past(port1_transceiver_event)}))
    else $error("transceiver bits do not follow their sources");

  // a clear written in the cycle after the wrap may drop the bit one cycle later
  a_timer_sets: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
    timer_wrap |=> status_r[SIE_BIT_TIMER] ##1
      (status_r[SIE_BIT_TIMER] || $past(wr_status && reg_wdata[SIE_BIT_TIMER])))
    else $error("timer wrap not recorded");

  a_master_tracks: assert property (@(posedge clk) disable iff (!arst_n) // RQ14
    irq_master == |($past(status_nxt) & $past(enable_r)))
    else $error("master indication mismatches enabled status");

  a_pin_gated: assert property (@(posedge clk) disable iff (!arst_n) // RQ15
    !$past(irq_output_enable) |-> !irq_pin)
    else $error("interrupt pin asserted while output disabled");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n) // RQ18
    ((status_r | enable_r) & ~SIE_EVENT_MASK) == 32'h0000_0000)
    else $error("reserved position holds a one");

  a_pins_follow: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
    ##1 (status_r[SIE_BIT_PINS] == $past(pif.event_any)))
    else $error("pin event bit does not follow enabled pin status");

  // the software bit is not a level follower, only an enable rise sets it
  a_sw_no_level: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
    (!status_r[SIE_BIT_SOFTWARE] &&
     !(wr_enable && reg_wdata[SIE_BIT_SOFTWARE] && !enable_r[SIE_BIT_SOFTWARE]))
      |=> !status_r[SIE_BIT_SOFTWARE])
    else $error("software status bit set without enable rise");

  a_ready_single: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
    (ready_done_r && !status_r[SIE_BIT_READY]) |=> !status_r[SIE_BIT_READY])
    else $error("ready status bit set twice in one reset period");

  a_timer_quiet: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
    (!timer_wrap && !status_r[SIE_BIT_TIMER]) |=> !status_r[SIE_BIT_TIMER])
    else $error("timer status bit set without a wrap");

  a_enable_write: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
    wr_enable |=> (enable_r == ($past(reg_wdata) & SIE_EVENT_MASK)))
    else $error("enable register does not hold the written event bits");

  a_irq_pin_gate: assert property (@(posedge clk) disable iff (!arst_n) // RQ15
    irq_pin == (irq_master && $past(irq_output_enable)))
    else $error("interrupt pin differs from gated master indication");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!arst_n) // RQ18
    (reg_rd && !hit(reg_addr, SIE_OFF_STATUS) && !hit(reg_addr, SIE_OFF_ENABLE) &&
     !hit(reg_addr, SIE_OFF_PINCFG)) |=> (reg_rdata == 32'h0000_0000))
    else $error("unmapped offset read back nonzero");

endmodule : sie_top

//--- sie_host_model.sv
// host model driving the management port
`timescale 1ns/10ps
module sie_host_model
  import sie_pkg::*;
(
  input  wire logic                  clk,
  output logic                       reg_wr,
  output logic                       reg_rd,
  output logic      [SIE_ADDR_W-1:0] reg_addr,
  output logic      [SIE_DATA_W-1:0] reg_wdata,
  input  wire logic [SIE_DATA_W-1:0] reg_rdata,
  input  wire logic                  reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
  end

  task automatic wr(input logic [SIE_ADDR_W-1:0] a, input logic [SIE_DATA_W-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    // released data is inverted so a stale word never looks valid
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [SIE_ADDR_W-1:0] a, output logic [SIE_DATA_W-1:0] d);
    int n;
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 8);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask : rd
endmodule : sie_host_model

//--- tb_system_interrupt_status_enable.sv
// self-checking testbench of the interrupt status and enable block
`timescale 1ns/10ps
module tb_system_interrupt_status_enable
  import sie_pkg::*;
;
  logic                  clk;
  logic                  arst_n;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [SIE_ADDR_W-1:0] reg_addr;
  logic [SIE_DATA_W-1:0] reg_wdata;
  logic [SIE_DATA_W-1:0] reg_rdata;
  logic                  reg_rvalid;
  logic                  dev_rdy;
  logic [2:0]            src;
  logic [15:0]           tcnt;
  logic [5:0]            pin_in;
  logic [5:0]            pdata;
  logic [5:0]            pdir;
  logic [5:0]            pen;
  logic [5:0]            pclr;
  logic [5:0]            pin_status;
  logic [5:0]            pin_o;
  logic [5:0]            pin_oe_n;
  logic [5:0]            ext_en;
  logic [5:0]            ext_val;
  logic                  irq_oe;
  logic                  irq_master;
  logic                  irq_pin;
  logic [31:0]           d;
  int                    num_errors;
  int                    cmp_count;

  // pin level: design drive, else outside drive, else pull-up
  assign pin_in = (~pin_oe_n & pin_o) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);

  sie_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  sie_top u_dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .device_ready(dev_rdy), .fabric_pending(src[2]),
    .port2_transceiver_event(src[1]), .port1_transceiver_event(src[0]),
    .timer_count(tcnt), .pin_in(pin_in), .pin_out_data(pdata), .pin_dir_out(pdir),
    .pin_event_status_enable(pen), .pin_status_clear(pclr), .pin_status(pin_status),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq_output_enable(irq_oe),
    .irq_master(irq_master), .irq_pin(irq_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk_reg(input logic [SIE_ADDR_W-1:0] a, input logic [31:0] e);
    u_host.rd(a, d);
    cmp_count++;
    if (d !== e) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, d, e);
    end
  endtask : chk_reg

  task automatic chk_sig(input logic [5:0] g, input logic [5:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_sig

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic t_reset();
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    chk_reg(SIE_OFF_ENABLE, 32'h0000_0000);
    chk_reg(SIE_OFF_PINCFG, 32'h0000_0000);
    chk_reg(9'h100, 32'h0000_0000);
    dev_rdy <= 1'b1;
    tick(2);
    chk_reg(SIE_OFF_STATUS, 32'h4000_0000);
    u_host.wr(SIE_OFF_STATUS, 32'h0000_0000);
    chk_reg(SIE_OFF_STATUS, 32'h4000_0000);
    u_host.wr(SIE_OFF_STATUS, 32'h4000_0000);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    u_host.wr(SIE_OFF_ENABLE, 32'hffff_ffff);
    chk_reg(SIE_OFF_ENABLE, 32'hdc08_1000);
    u_host.wr(SIE_OFF_ENABLE, 32'h0000_0000);
    u_host.wr(SIE_OFF_STATUS, 32'hffff_ffff);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_soft();
    u_host.wr(SIE_OFF_ENABLE, 32'h8000_0000);
    chk_reg(SIE_OFF_STATUS, 32'h8000_0000);
    tick(2);
    chk_sig({5'h00, irq_master}, 6'h01);
    chk_sig({5'h00, irq_pin}, 6'h00);
    irq_oe <= 1'b1;
    tick(2);
    chk_sig({5'h00, irq_pin}, 6'h01);
    u_host.wr(SIE_OFF_STATUS, 32'h8000_0000);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    chk_sig({4'h0, irq_master, irq_pin}, 6'h00);
    u_host.wr(SIE_OFF_ENABLE, 32'h0000_0000);
    $display("test software done");
  endtask : t_soft

  task automatic t_sources();
    logic [31:0] b;
    for (int k = 0; k < 3; k++) begin
      b = 32'h0400_0000 << k;
      src <= 3'h1 << k;
      tick(2);
      chk_reg(SIE_OFF_STATUS, b);
      chk_sig({5'h00, irq_master}, 6'h00);
      u_host.wr(SIE_OFF_ENABLE, b);
      tick(2);
      chk_sig({5'h00, irq_master}, 6'h01);
      src <= 3'h0;
      tick(2);
      chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
      u_host.wr(SIE_OFF_ENABLE, 32'h0000_0000);
    end
    $display("test sources done");
  endtask : t_sources

  task automatic t_timer();
    tcnt <= 16'h0005;
    tick(1);
    tcnt <= 16'h0004;
    tick(2);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    tcnt <= 16'h0000;
    tick(1);
    tcnt <= 16'hffff;
    tick(2);
    chk_reg(SIE_OFF_STATUS, 32'h0008_0000);
    u_host.wr(SIE_OFF_STATUS, 32'h0008_0000);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    $display("test timer done");
  endtask : t_timer

  task automatic t_pins();
    u_host.wr(SIE_OFF_PINCFG, 32'hffff_ffff);
    chk_reg(SIE_OFF_PINCFG, 32'h003f_003f);
    tick(4);
    chk_sig(pin_status, 6'h3f);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    pen <= 6'h04;
    tick(4);
    chk_reg(SIE_OFF_STATUS, 32'h0000_1000);
    u_host.wr(SIE_OFF_PINCFG, 32'h0000_003f);
    ext_en  <= 6'h3f;
    ext_val <= 6'h3e;
    pclr    <= 6'h3f;
    tick(1);
    pclr    <= 6'h00;
    tick(4);
    chk_sig(pin_status, 6'h01);
    chk_reg(SIE_OFF_STATUS, 32'h0000_0000);
    ext_en <= 6'h3c;
    pdir   <= 6'h03;
    pdata  <= 6'h02;
    u_host.wr(SIE_OFF_PINCFG, 32'h0000_0002);
    tick(4);
    chk_sig(pin_oe_n, 6'h3c);
    chk_sig({4'h0, pin_o[1:0]}, 6'h02);
    pdata <= 6'h03;
    tick(4);
    // open-drain pin with data one must float
    chk_sig(pin_oe_n, 6'h3d);
    pdir <= 6'h00;
    $display("test pins done");
  endtask : t_pins

  initial begin
    arst_n  = 1'b0;
    dev_rdy = 1'b0;
    src     = 3'h0;
    tcnt    = 16'h1234;
    pdata   = 6'h00;
    pdir    = 6'h00;
    pen     = 6'h00;
    pclr    = 6'h00;
    ext_en  = 6'h00;
    ext_val = 6'h00;
    irq_oe  = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    tick(10);
    arst_n <= 1'b1;
    tick(1);
    t_reset();
    t_soft();
    t_sources();
    t_timer();
    t_pins();
    print_verdict();
  end

  // run needs well under 2000 cycles
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_system_interrupt_status_enable
